// >>> hw/port8_pin_function_mux.sv
/*
  eight-pin port with per-pin function mux, direction, drive mode and data, APB slave.
  assumes a synchronous APB master on i_ref_clk, pads resolving out/oe/pulls outside,
  and pin inputs that are asynchronous to i_ref_clk.
// Operation
// - two r/w selector registers; bit n of both forms pin n's 2-bit selector
// - pin 7: 00 port, 01 uart a transmit, 10 pwm a, 11 reserved
// - pin 6: 00 port, 01 uart a receive, 10 serial data out, 11 reserved
// - pin 5: 00 port, 01 uart b transmit, 10 serial clock, 11 reserved
// - pin 4: 00 port, 01 uart b receive, 10 serial data in, 11 reserved
// - pin 3: 00 port, 10 pwm b, 01 and 11 reserved
// - pin 2: 00 port, 10 serial data out, 01 and 11 reserved
// - pin 1: 00 port, 01 i2c clock, 10 serial clock, 11 reserved
// - pin 0: 00 port, 01 i2c data, 10 serial data in, 11 reserved
// - both selector registers reset to zero, port function everywhere
// - reserved code, output, hi-z or p open drain: pin stays hi-z
// - reserved code, output, n open drain or cmos: pin driven low
// - each pin has its own direction bit
// - direction 0 means output, 1 means input
// - output: drive code picks hi-z, p open drain, n open drain or cmos
// - input: drive code picks hi-z, pull-down or pull-up
// - codes 00 hi-z, 01 pod/pull-down, 10 nod/pull-up, 11 cmos/hi-z input
// - reset leaves every pin in hi-z output mode
// - output with port function drives data register bit
// - input mode: data register read returns pin level
*/
`include "port8_pin_function_mux_consts.svh"

module port8_pin_function_mux
  import port8_pin_function_mux_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int PINS   = 8
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic      [31:0]       o_prdata,
  output logic                   o_pslverr,
  input  wire logic [PINS-1:0]   i_pin_in,
  output logic      [PINS-1:0]   o_pin_out,
  output logic      [PINS-1:0]   o_pin_oe,
  output logic      [PINS-1:0]   o_pin_pull_up,
  output logic      [PINS-1:0]   o_pin_pull_down,
  input  wire logic              i_uart_a_transmit,
  input  wire logic              i_uart_b_transmit,
  input  wire logic              i_pwm_a_output,
  input  wire logic              i_pwm_b_output,
  input  wire logic              i_sync_serial_data_out,
  input  wire logic              i_sync_serial_clock_out,
  input  wire logic              i_i2c_clock_out,
  input  wire logic              i_i2c_data_out,
  output logic                   o_uart_a_receive,
  output logic                   o_uart_b_receive,
  output logic                   o_sync_serial_data_in,
  output logic                   o_sync_serial_clock_in,
  output logic                   o_i2c_clock_in,
  output logic                   o_i2c_data_in
);

  logic [7:0]      fsel_lo_ff;
  logic [7:0]      fsel_hi_ff;
  logic [7:0]      pdir_ff;
  logic [7:0]      drv_lo_ff;
  logic [7:0]      drv_hi_ff;
  logic [7:0]      pdata_ff;
  logic            pready_ff;
  logic [31:0]     prdata_ff;
  logic            pslverr_ff;
  logic [7:0]      pin_meta_ff;
  logic [7:0]      pin_sync_ff;
  logic [7:0]      pin_out_ff;
  logic [7:0]      pin_oe_ff;
  logic [7:0]      pin_pu_ff;
  logic [7:0]      pin_pd_ff;
  logic            ua_rx_ff;
  logic            ub_rx_ff;
  logic            ss_in_ff;
  logic            ss_clk_ff;
  logic            i2c_clk_ff;
  logic            i2c_dat_ff;
  logic [7:0]      nxt_pin_out;
  logic [7:0]      nxt_pin_oe;
  logic [7:0]      nxt_pin_pu;
  logic [7:0]      nxt_pin_pd;
  logic [7:0]      alt1_val;
  logic [7:0]      alt2_val;
  logic [31:0]     nxt_prdata;
  logic            nxt_hit;
  logic            access;
  logic            done;
  logic            wr_en;
  pin_function_t   fsel [8];

  // word decode of one register index
  function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction : word_hit

  // reserved selector codes per pin
  function automatic logic is_reserved(input int pin, input pin_function_t f);
    logic [7:0] m;
    m = `RSV01_MASK;
    return (f == FN_RSV) || (f == FN_ALT1 && m[pin]);
  endfunction : is_reserved

  // pad control from direction, drive code, reserved flag and value
  function automatic pin_drive_t drive_of(input logic dir_in, input drive_mode_t m,
                                          input logic rsv, input logic v);
    pin_drive_t d;
    d = '{oe: 1'b0, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0};
    if (dir_in) begin
      d.pull_down = (m == DRV_POD);
      d.pull_up   = (m == DRV_NOD);
    end else if (rsv) begin
      d.oe  = (m == DRV_NOD) || (m == DRV_CMOS);
      d.out = 1'b0;
    end else begin
      case (m)
        DRV_POD: begin
          d.oe  = v;
          d.out = 1'b1;
        end
        DRV_NOD: begin
          d.oe  = ~v;
          d.out = 1'b0;
        end
        DRV_CMOS: begin
          d.oe  = 1'b1;
          d.out = v;
        end
        default: begin
          d.oe  = 1'b0;
          d.out = 1'b0;
        end
      endcase
    end
    return d;
  endfunction : drive_of

  // apb handshake: answer one cycle after the access phase opens
  assign access = i_psel & i_penable;
  assign done   = access & pready_ff;
  assign wr_en  = done & i_pwrite & ~pslverr_ff & i_pstrb[0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access & ~pready_ff;
    end
  end

  // read mux and decode
  always_comb begin
    nxt_prdata = `PRDATA_RST;
    nxt_hit    = 1'b1;
    if (word_hit(i_paddr, `FSEL_LO_IDX)) begin
      nxt_prdata[7:0] = fsel_lo_ff;
    end else if (word_hit(i_paddr, `FSEL_HI_IDX)) begin
      nxt_prdata[7:0] = fsel_hi_ff;
    end else if (word_hit(i_paddr, `PDATA_IDX)) begin
      nxt_prdata[7:0] = (pdir_ff & pin_sync_ff) | (~pdir_ff & pdata_ff);
    end else if (word_hit(i_paddr, `PDIR_IDX)) begin
      nxt_prdata[7:0] = pdir_ff;
    end else if (word_hit(i_paddr, `DRV_LO_IDX)) begin
      nxt_prdata[7:0] = drv_lo_ff;
    end else if (word_hit(i_paddr, `DRV_HI_IDX)) begin
      nxt_prdata[7:0] = drv_hi_ff;
    end else begin
      nxt_hit = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prdata_ff  <= `PRDATA_RST;
      pslverr_ff <= 1'b0;
    end else if (access & ~pready_ff) begin
      prdata_ff  <= i_pwrite ? `PRDATA_RST : nxt_prdata;
      pslverr_ff <= ~nxt_hit;
    end
  end

  // register writes take effect at the completing edge
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fsel_lo_ff <= `FSEL_RST;
      fsel_hi_ff <= `FSEL_RST;
    end else if (wr_en && word_hit(i_paddr, `FSEL_LO_IDX)) begin
      fsel_lo_ff <= i_pwdata[7:0];
    end else if (wr_en && word_hit(i_paddr, `FSEL_HI_IDX)) begin
      fsel_hi_ff <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pdir_ff   <= `PDIR_RST;
      drv_lo_ff <= `DRV_RST;
      drv_hi_ff <= `DRV_RST;
      pdata_ff  <= `PDATA_RST;
    end else if (wr_en && word_hit(i_paddr, `PDIR_IDX)) begin
      pdir_ff <= i_pwdata[7:0];
    end else if (wr_en && word_hit(i_paddr, `DRV_LO_IDX)) begin
      drv_lo_ff <= i_pwdata[7:0];
    end else if (wr_en && word_hit(i_paddr, `DRV_HI_IDX)) begin
      drv_hi_ff <= i_pwdata[7:0];
    end else if (wr_en && word_hit(i_paddr, `PDATA_IDX)) begin
      pdata_ff <= i_pwdata[7:0];
    end
  end

  // pin input synchroniser
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_meta_ff <= 8'h00;
      pin_sync_ff <= 8'h00;
    end else begin
      pin_meta_ff <= i_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // alternate output sources per pin
  always_comb begin
    alt1_val = {i_uart_a_transmit, pdata_ff[6], i_uart_b_transmit, pdata_ff[4],
                pdata_ff[3], pdata_ff[2], i_i2c_clock_out, i_i2c_data_out};
    alt2_val = {i_pwm_a_output, i_sync_serial_data_out, i_sync_serial_clock_out,
                pdata_ff[4], i_pwm_b_output, i_sync_serial_data_out,
                i_sync_serial_clock_out, pdata_ff[0]};
  end

  always_comb begin
    pin_drive_t d;
    logic       v;
    d           = '{oe: 1'b0, out: 1'b0, pull_up: 1'b0, pull_down: 1'b0};
    v           = 1'b0;
    nxt_pin_out = 8'h00;
    nxt_pin_oe  = 8'h00;
    nxt_pin_pu  = 8'h00;
    nxt_pin_pd  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      fsel[i] = pin_function_t'({fsel_hi_ff[i], fsel_lo_ff[i]});
      case (fsel[i])
        FN_ALT1: v = alt1_val[i];
        FN_ALT2: v = alt2_val[i];
        default: v = pdata_ff[i];
      endcase
      d = drive_of(pdir_ff[i], drive_mode_t'({drv_hi_ff[i], drv_lo_ff[i]}),
                   is_reserved(i, fsel[i]), v);
      nxt_pin_out[i] = d.out;
      nxt_pin_oe[i]  = d.oe;
      nxt_pin_pu[i]  = d.pull_up;
      nxt_pin_pd[i]  = d.pull_down;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pin_out_ff <= 8'h00;
      pin_oe_ff  <= 8'h00;
      pin_pu_ff  <= 8'h00;
      pin_pd_ff  <= 8'h00;
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      pin_pu_ff  <= nxt_pin_pu;
      pin_pd_ff  <= nxt_pin_pd;
    end
  end

  // pin levels routed to peripherals, idle level when not selected
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ua_rx_ff   <= `IDLE_HIGH;
      ub_rx_ff   <= `IDLE_HIGH;
      ss_in_ff   <= `IDLE_LOW;
      ss_clk_ff  <= `IDLE_HIGH;
      i2c_clk_ff <= `IDLE_HIGH;
      i2c_dat_ff <= `IDLE_HIGH;
    end else begin
      ua_rx_ff   <= (fsel[`PIN_UA_RX] == FN_ALT1) ? pin_sync_ff[`PIN_UA_RX] : `IDLE_HIGH;
      ub_rx_ff   <= (fsel[`PIN_UB_RX] == FN_ALT1) ? pin_sync_ff[`PIN_UB_RX] : `IDLE_HIGH;
      ss_in_ff   <= (fsel[`PIN_SS_IN_A] == FN_ALT2) ? pin_sync_ff[`PIN_SS_IN_A] :
                    (fsel[`PIN_SS_IN_B] == FN_ALT2) ? pin_sync_ff[`PIN_SS_IN_B] :
                    `IDLE_LOW;
      ss_clk_ff  <= (fsel[`PIN_SS_CLK_A] == FN_ALT2) ? pin_sync_ff[`PIN_SS_CLK_A] :
                    (fsel[`PIN_SS_CLK_B] == FN_ALT2) ? pin_sync_ff[`PIN_SS_CLK_B] :
                    `IDLE_HIGH;
      i2c_clk_ff <= (fsel[`PIN_I2C_CLK] == FN_ALT1) ? pin_sync_ff[`PIN_I2C_CLK] :
                    `IDLE_HIGH;
      i2c_dat_ff <= (fsel[`PIN_I2C_DATA] == FN_ALT1) ? pin_sync_ff[`PIN_I2C_DATA] :
                    `IDLE_HIGH;
    end
  end

  assign o_pready               = pready_ff;
  assign o_prdata               = prdata_ff;
  assign o_pslverr              = pslverr_ff;
  assign o_pin_out              = pin_out_ff;
  assign o_pin_oe               = pin_oe_ff;
  assign o_pin_pull_up          = pin_pu_ff;
  assign o_pin_pull_down        = pin_pd_ff;
  assign o_uart_a_receive       = ua_rx_ff;
  assign o_uart_b_receive       = ub_rx_ff;
  assign o_sync_serial_data_in  = ss_in_ff;
  assign o_sync_serial_clock_in = ss_clk_ff;
  assign o_i2c_clock_in         = i2c_clk_ff;
  assign o_i2c_data_in          = i2c_dat_ff;

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_open_access;
    i_psel && i_penable && !o_pready;
  endsequence

  sequence s_fsel_lo_write;
    i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0] && !o_pslverr &&
    word_hit(i_paddr, `FSEL_LO_IDX);
  endsequence

  a_apb_ready_next: assert property (s_open_access |=> o_pready)
    else $error("pready not raised one cycle after access opened");

  a_fsel_lo_store: assert property (s_fsel_lo_write |=> fsel_lo_ff == $past(i_pwdata[7:0]))
    else $error("low selector write not stored");

  a_reset_zero: assert property ($fell(i_rst) |-> fsel_lo_ff == `FSEL_RST &&
                                 fsel_hi_ff == `FSEL_RST && pin_oe_ff == 8'h00)
    else $error("selectors or pads not at reset state");

  generate
    for (genvar p = 0; p < 8; p++) begin : g_pin_chk
      a_rsv_hiz: assert property (
        !pdir_ff[p] && is_reserved(p, fsel[p]) && !drv_hi_ff[p] |=> !o_pin_oe[p])
        else $error("reserved pin not high-impedance");
      a_rsv_low: assert property (
        !pdir_ff[p] && is_reserved(p, fsel[p]) && drv_hi_ff[p]
        |=> o_pin_oe[p] && !o_pin_out[p])
        else $error("reserved pin not driven low");
      a_cmos_data: assert property (
        !pdir_ff[p] && fsel[p] == FN_PORT && drv_hi_ff[p] && drv_lo_ff[p]
        |=> o_pin_oe[p] && o_pin_out[p] == $past(pdata_ff[p]))
        else $error("cmos port pin does not follow data");
      a_input_float: assert property (
        pdir_ff[p] |=> !o_pin_oe[p] &&
        o_pin_pull_up[p] == $past(drv_hi_ff[p] && !drv_lo_ff[p]) &&
        o_pin_pull_down[p] == $past(!drv_hi_ff[p] && drv_lo_ff[p]))
        else $error("input pin drive or pull wrong");
    end
  endgenerate

  a_uart_a_route: assert property (
    fsel[`PIN_UA_RX] == FN_ALT1 |=> o_uart_a_receive == $past(pin_sync_ff[`PIN_UA_RX]))
    else $error("uart a receive not routed from pin");

  a_pin_read_sync: assert property (
    i_psel && i_penable && !o_pready && !i_pwrite && word_hit(i_paddr, `PDATA_IDX)
    |=> o_prdata[7:0] == ($past(pdir_ff & pin_sync_ff) | $past(~pdir_ff & pdata_ff)))
    else $error("data register read wrong");

  a_unmapped_err: assert property (
    s_open_access ##0 !nxt_hit |=> o_pready && o_pslverr)
    else $error("unmapped access not flagged");

endmodule : port8_pin_function_mux

// >>> hw/port8_pin_function_mux_consts.svh
/*
  register indices, reset values and field layout constants for the port-8 pin mux.
  assumes inclusion by bare name; definitions only.
*/
`ifndef PORT8_PIN_FUNCTION_MUX_CONSTS_SVH
`define PORT8_PIN_FUNCTION_MUX_CONSTS_SVH

// register indices, byte address is four times the index
`define FSEL_LO_IDX   16'hF2E2
`define FSEL_HI_IDX   16'hF2E3
`define PDATA_IDX     16'hF2D8
`define PDIR_IDX      16'hF2D9
`define DRV_LO_IDX    16'hF2DA
`define DRV_HI_IDX    16'hF2DB

// reset values
`define FSEL_RST      8'h00
`define PDIR_RST      8'h00
`define DRV_RST       8'h00
`define PDATA_RST     8'h00
`define PRDATA_RST    32'h0000_0000

// pins whose selector code 01 is reserved
`define RSV01_MASK    8'h0C

// pin positions of the alternate functions
`define PIN_I2C_DATA  3'h0
`define PIN_I2C_CLK   3'h1
`define PIN_SS_IN_B   3'h0
`define PIN_SS_CLK_B  3'h1
`define PIN_SS_IN_A   3'h4
`define PIN_SS_CLK_A  3'h5
`define PIN_UB_RX     3'h4
`define PIN_UA_RX     3'h6

// idle levels of peripheral inputs when no pin is routed
`define IDLE_HIGH     1'h1
`define IDLE_LOW      1'h0

`endif

// >>> hw/port8_pin_function_mux_pkg.sv
/*
  types shared by the port-8 pin mux.
  assumes nothing of its surroundings.
*/
package port8_pin_function_mux_pkg;

  typedef enum logic [1:0] {
    FN_PORT = 2'h0,
    FN_ALT1 = 2'h1,
    FN_ALT2 = 2'h2,
    FN_RSV  = 2'h3
  } pin_function_t;

  typedef enum logic [1:0] {
    DRV_HIZ  = 2'h0,
    DRV_POD  = 2'h1,
    DRV_NOD  = 2'h2,
    DRV_CMOS = 2'h3
  } drive_mode_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pull_up;
    logic pull_down;
  } pin_drive_t;

endpackage : port8_pin_function_mux_pkg

// >>> testbench/port8_pad_model.sv
/*
  board and pad model for the eight port pins: resolves each pin level.
  assumes pad drive signals from the port block and a board driver per pin.
*/
module port8_pad_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull_up,
  input  wire logic [7:0] i_pull_down,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_en,
  output logic      [7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] last_ff;

  always_ff @(posedge i_ref_clk) begin
    last_ff <= o_level;
  end

  // pad drive wins, then the board, then a pull; a floating pin flips so no stale level hides
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_oe[i]) begin
        o_level[i] = i_out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext_val[i];
      end else if (i_pull_up[i] | i_pull_down[i]) begin
        o_level[i] = i_pull_up[i];
      end else begin
        o_level[i] = ~last_ff[i];
      end
    end
  end
endmodule : port8_pad_model

// >>> testbench/tb_port8_pin_function_mux.sv
/*
  self-checking bench for the port-8 pin mux: apb register access, pad and peripheral routing.
  assumes the consts header on the include path and the pad model compiled before.
*/
`include "port8_pin_function_mux_consts.svh"

module tb_port8_pin_function_mux;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  lvl, pin_out, pin_oe, pin_pu, pin_pd, ext_val, ext_en, periph, rx_seen;
  logic [5:0]  rx;
  logic [7:0]  v8;
  logic [15:0] idx_tab [6];
  integer      seed = 32'h9020B098;
  int          fail_count = 0;
  int          samples_checked = 0;

  assign rx_seen = {2'h0, rx};

  port8_pin_function_mux uut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_pin_in(lvl), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pin_pull_up(pin_pu), .o_pin_pull_down(pin_pd),
    .i_uart_a_transmit(periph[7]), .i_uart_b_transmit(periph[6]),
    .i_pwm_a_output(periph[5]), .i_pwm_b_output(periph[4]),
    .i_sync_serial_data_out(periph[3]), .i_sync_serial_clock_out(periph[2]),
    .i_i2c_clock_out(periph[1]), .i_i2c_data_out(periph[0]),
    .o_uart_a_receive(rx[5]), .o_uart_b_receive(rx[4]), .o_sync_serial_data_in(rx[3]),
    .o_sync_serial_clock_in(rx[2]), .o_i2c_clock_in(rx[1]), .o_i2c_data_in(rx[0])
  );

  port8_pad_model pads (
    .i_ref_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .i_pull_up(pin_pu),
    .i_pull_down(pin_pd), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(lvl)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // one apb transfer; read data and error taken at the edge that sees pready
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     input logic [3:0] st);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {14'h0, idx, 2'h0};
    pwdata  <= {24'hA5A5A5, wd};
    pstrb   <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] r8();
    return 8'($random(seed));
  endfunction : r8

  // value a pin carries for its selected function
  function automatic logic exp_v(input int p, input logic [1:0] c, input logic d,
                                 input logic [7:0] pr);
    if (c == 2'h1) begin
      case (p)
        7: return pr[7];
        5: return pr[6];
        1: return pr[1];
        0: return pr[0];
        default: return d;
      endcase
    end
    if (c == 2'h2) begin
      case (p)
        7: return pr[5];
        6, 2: return pr[3];
        5, 1: return pr[2];
        3: return pr[4];
        default: return d;
      endcase
    end
    return d;
  endfunction : exp_v

  // {oe, out, pull_up, pull_down} of one pin
  function automatic logic [3:0] exp_pin(input logic dir, input logic [1:0] drv,
                                         input logic rsv, input logic v);
    if (dir) return {2'h0, drv == 2'h2, drv == 2'h1};
    if (rsv) return {drv[1], 3'h0};
    case (drv)
      2'h1: return {v, 3'h4};
      2'h2: return {~v, 3'h0};
      2'h3: return {1'h1, v, 2'h0};
      default: return 4'h0;
    endcase
  endfunction : exp_pin

  task automatic run_case(input logic [7:0] fl, fh, dr, dl, dh, dt, pr, rn);
    logic [7:0] v [6];
    logic [7:0] eoe, eout, epu, epd, el, en, ev;
    logic [5:0] erx;
    logic [1:0] s [8];
    v = '{fl, fh, dr, dl, dh, dt};
    for (int i = 0; i < 6; i++) apb(1'h1, idx_tab[i], v[i], 4'hF);
    ev = r8();
    for (int p = 0; p < 8; p++) begin
      s[p] = {fh[p], fl[p]};
      {eoe[p], eout[p], epu[p], epd[p]} = exp_pin(dr[p], {dh[p], dl[p]},
        s[p] == 2'h3 || (s[p] == 2'h1 && (p == 3 || p == 2)), exp_v(p, s[p], dt[p], pr));
    end
    en = (~eoe & ~(epu | epd)) | rn;
    el = (eoe & eout) | (~eoe & en & ev) | (~eoe & ~en & epu);
    erx = {s[6] == 2'h1 ? el[6] : 1'h1, s[4] == 2'h1 ? el[4] : 1'h1,
           s[4] == 2'h2 ? el[4] : (s[0] == 2'h2 ? el[0] : 1'h0),
           s[5] == 2'h2 ? el[5] : (s[1] == 2'h2 ? el[1] : 1'h1),
           s[1] == 2'h1 ? el[1] : 1'h1, s[0] == 2'h1 ? el[0] : 1'h1};
    @(posedge clk);
    periph  <= pr;
    ext_val <= ev;
    ext_en  <= en;
    repeat (6) @(posedge clk);
    check(pin_oe, eoe);
    check(pin_out & eoe, eout & eoe);
    check(pin_pu, epu);
    check(pin_pd, epd);
    check(rx_seen, {2'h0, erx});
    apb(1'h0, `PDATA_IDX, 8'h00, 4'hF);
    check(rd[7:0] & dr, el & dr);
  endtask : run_case

  initial begin
    idx_tab = '{`FSEL_LO_IDX, `FSEL_HI_IDX, `PDIR_IDX, `DRV_LO_IDX, `DRV_HI_IDX, `PDATA_IDX};
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {periph, ext_val} = '0;
    ext_en = 8'hFF;
    rst = 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    check(pin_oe | pin_pu | pin_pd, 8'h00);
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, idx_tab[i], 8'h00, 4'hF);
      check(rd[7:0], 8'h00);
      check(rd[31:24] | rd[23:16] | rd[15:8] | {7'h0, err}, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      v8 = r8();
      apb(1'h1, idx_tab[i], v8, 4'hF);
      apb(1'h1, idx_tab[i], ~v8, 4'h0);
      apb(1'h0, idx_tab[i], 8'h00, 4'hF);
      check(rd[7:0], v8);
    end
    apb(1'h0, 16'hF2E4, 8'h00, 4'hF);
    check(rd[7:0] | rd[31:24], 8'h00);
    check({7'h0, err}, 8'h01);
    run_case(8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00);
    run_case(8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00);
    run_case(8'h0C, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00);
    run_case(8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00);
    run_case(8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00);
    for (int c = 0; c < 4; c++) begin
      run_case({8{c[0]}}, {8{c[1]}}, 8'h00, 8'hFF, 8'hFF, r8(), r8(), 8'h00);
    end
    repeat (60) run_case(r8(), r8(), r8(), r8(), r8(), r8(), r8(), r8());
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_port8_pin_function_mux
